// file: design/cqr_pkg.sv
// Purpose: constants for the channel b line control and channel a error registers
// Assumes: ahb-lite word registers, 10 MHz ref clock
// Notes:   offset 0x07 is not word aligned, so offsets 0x07/0x08 are kept as indices
//
// Summary of operation
// RULE_01 - rate field 01/10/11 selects 4.8/38.4/230.4k; 00=230.4k
// RULE_02 - establish runs wake and detect, then irq, clears
// RULE_03 - wake pulse overrides current limit above 500 mA; code boosts only the establish wake, not a bare wake
// RULE_04 - success stores detected rate and remote period
// RULE_05 - failure raises irq, clears establish and rate
// RULE_06 - host sets framer enable before establish
// RULE_07 - wake bit emits wake request, cleared when done
// RULE_08 - after software wake request, line goes receive
// RULE_09 - host uses bare wake only without establish
// RULE_10 - tx queue clear bit empties transmit queue
// RULE_11 - rx queue clear bit empties receive queue
// RULE_12 - timer arm bit arms only, no counting
// RULE_13 - armed timer starts on send or trigger
// RULE_14 - clearing arm stops timer at once
// RULE_15 - send transmits queue, then returns to receive
// RULE_16 - send bit clears itself automatically
// RULE_17 - error register read-only, zero at reset, clear-on-read
// RULE_18 - bit 7 flags channel a transmission fault
// RULE_19 - send while disarmed transmits once, no timer
package cqr_pkg;
  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] CQR_IDX_CTRL_B = 8'h07;
  localparam logic [7:0] CQR_IDX_ERR_A  = 8'h08;
  localparam logic [7:0] CQR_IDX_IRQ_ST = 8'h10;
  localparam logic [7:0] CQR_IDX_IRQ_MK = 8'h11;
  localparam logic [7:0] CQR_IDX_CFG    = 8'h12;
  localparam logic [7:0] CQR_IDX_PERIOD = 8'h13;
  localparam logic [9:0] CQR_ADR_CTRL_B = {CQR_IDX_CTRL_B, 2'b00};
  localparam logic [9:0] CQR_ADR_ERR_A  = {CQR_IDX_ERR_A, 2'b00};
  localparam logic [9:0] CQR_ADR_IRQ_ST = {CQR_IDX_IRQ_ST, 2'b00};
  localparam logic [9:0] CQR_ADR_IRQ_MK = {CQR_IDX_IRQ_MK, 2'b00};
  localparam logic [9:0] CQR_ADR_CFG    = {CQR_IDX_CFG, 2'b00};
  localparam logic [9:0] CQR_ADR_PERIOD = {CQR_IDX_PERIOD, 2'b00};
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CQR_B_RATE_HI  = 7;
  localparam int CQR_B_RATE_LO  = 6;
  localparam int CQR_B_ESTAB    = 5;
  localparam int CQR_B_WAKE     = 4;
  localparam int CQR_B_TXCLR    = 3;
  localparam int CQR_B_RXCLR    = 2;
  localparam int CQR_B_ARM      = 1;
  localparam int CQR_B_SEND     = 0;
  localparam int CQR_B_TXFAULT  = 7;
  localparam int CQR_I_WAKEDONE = 0;
  localparam int CQR_I_TXFAULT  = 1;
  localparam int CQR_C_FRAMER   = 0;
  // ---------------------------------------------------------------
  // reset values and rate codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CQR_RST_CTRL_B = 8'h00;
  localparam logic [7:0] CQR_RST_ERR_A  = 8'h00;
  localparam logic [1:0] CQR_RATE_FAIL  = 2'h0;
  localparam logic [1:0] CQR_RATE_COM1  = 2'h1;
  localparam logic [1:0] CQR_RATE_COM2  = 2'h2;
  localparam logic [1:0] CQR_RATE_COM3  = 2'h3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CQR_CLK_HZ     = 10_000_000;
  localparam int CQR_WAKE_US    = 80;
  localparam int CQR_WAKE_CYC   = (CQR_WAKE_US * (CQR_CLK_HZ / 1_000_000));
  localparam int CQR_DETECT_CYC = 64;
  localparam int CQR_CNT_W      = 16;
  typedef enum logic [2:0] {
    CQR_IDLE   = 3'b000,
    CQR_WAKE   = 3'b001,
    CQR_DETECT = 3'b011,
    CQR_TX     = 3'b010,
    CQR_RX     = 3'b110
  } cqr_state_e;
endpackage

// file: design/cqr_regs.sv
// Purpose: channel b line control and channel a error registers on ahb-lite
// Assumes: single 10 MHz clock, synchronous active-low reset
// Notes:   detection results and faults arrive from framer logic on same clock
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cqr_regs
  import cqr_pkg::*;
#(
  parameter int WAKE_CYC   = CQR_WAKE_CYC,
  parameter int DETECT_CYC = CQR_DETECT_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // detection and line status from the framer
  input  wire logic        detect_ok_i,
  input  wire logic        detect_fail_i,
  input  wire logic [1:0]  detect_rate_i,
  input  wire logic [7:0]  detect_period_i,
  input  wire logic        trigger_i,
  input  wire logic        tx_queue_empty_i,
  input  wire logic        tx_fault_a_i,
  input  wire logic [6:0]  other_faults_a_i,
  // line pin b control
  output logic             line_pin_b_tx_o,
  output logic             line_pin_b_oe_n_o,
  output logic             current_boost_b_o,
  output logic             tx_queue_clear_b_o,
  output logic             rx_queue_clear_b_o,
  output logic             period_run_b_o,
  output logic      [1:0]  rate_sel_b_o,
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    cqr_state_e            st;
    logic                  by_estab;
    logic [CQR_CNT_W-1:0]  cnt;
    logic [7:0]            ctrl;
    logic [7:0]            err;
    logic [7:0]            period;
    logic [1:0]            irq_st;
    logic [1:0]            irq_mk;
    logic                  framer_on_b;
    logic                  run;
    logic                  ap_valid;
    logic                  ap_write;
    logic [9:0]            ap_addr;
    logic [31:0]           rdata;
    logic                  txclr;
    logic                  rxclr;
    logic                  irq;
    logic                  drv;
    logic                  oe_n;
    logic                  boost;
  } cqr_state_s;

  cqr_state_s s_q;
  cqr_state_s s_d;

  logic        addr_take;
  logic        rd_now;
  logic        wr_now;
  logic [7:0]  wd;
  logic [1:0]  ev;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    addr_take = hsel_i && hready_i && htrans_i[1];
    wr_now    = s_q.ap_valid && s_q.ap_write;
    rd_now    = addr_take && !hwrite_i;
    wd        = hwdata_i[7:0];
    ev        = 2'b00;
    s_d.txclr = 1'b0;
    s_d.rxclr = 1'b0;

    // data phase write
    if (wr_now) begin
      unique case (s_q.ap_addr)
        CQR_ADR_CTRL_B: begin
          s_d.ctrl[CQR_B_RATE_HI:CQR_B_RATE_LO] = wd[CQR_B_RATE_HI:CQR_B_RATE_LO]; // RULE_01
          s_d.ctrl[CQR_B_ESTAB] = s_q.ctrl[CQR_B_ESTAB] | wd[CQR_B_ESTAB];
          s_d.ctrl[CQR_B_WAKE]  = s_q.ctrl[CQR_B_WAKE] | wd[CQR_B_WAKE];
          s_d.ctrl[CQR_B_TXCLR] = wd[CQR_B_TXCLR];
          s_d.ctrl[CQR_B_RXCLR] = wd[CQR_B_RXCLR];
          s_d.ctrl[CQR_B_ARM]   = wd[CQR_B_ARM]; // RULE_12
          s_d.txclr = wd[CQR_B_TXCLR]; // RULE_10
          s_d.rxclr = wd[CQR_B_RXCLR]; // RULE_11
          if (!wd[CQR_B_ARM]) begin
            s_d.run = 1'b0; // RULE_14
          end
          if (wd[CQR_B_SEND]) begin
            if (s_q.ctrl[CQR_B_ARM] && wd[CQR_B_ARM]) begin
              s_d.run = 1'b1; // RULE_13
            end
            if (s_q.st == CQR_IDLE || s_q.st == CQR_RX) begin
              s_d.st = CQR_TX; // RULE_15 RULE_19
            end
          end
        end
        CQR_ADR_IRQ_ST: s_d.irq_st = s_q.irq_st & ~wd[1:0];
        CQR_ADR_IRQ_MK: s_d.irq_mk = wd[1:0];
        CQR_ADR_CFG:    s_d.framer_on_b = wd[CQR_C_FRAMER];
        default: begin
        end
      endcase
    end
    s_d.ctrl[CQR_B_SEND] = 1'b0; // RULE_16

    // trigger start of armed timer
    if (trigger_i && s_q.ctrl[CQR_B_ARM] && s_d.ctrl[CQR_B_ARM]) begin
      s_d.run = 1'b1; // RULE_13
    end

    // line sequencer
    unique case (s_q.st)
      CQR_IDLE, CQR_RX: begin
        if (s_d.st == CQR_IDLE || s_d.st == CQR_RX) begin
          if (s_d.ctrl[CQR_B_ESTAB] || s_d.ctrl[CQR_B_WAKE]) begin
            s_d.st       = CQR_WAKE;
            s_d.by_estab = s_d.ctrl[CQR_B_ESTAB];
            s_d.cnt      = '0;
          end
        end
      end
      CQR_WAKE: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == CQR_CNT_W'(WAKE_CYC - 1)) begin
          s_d.cnt = '0;
          if (s_q.by_estab) begin
            s_d.st = CQR_DETECT; // RULE_02
          end else begin
            s_d.st = CQR_RX; // RULE_08
            s_d.ctrl[CQR_B_WAKE] = 1'b0; // RULE_07
          end
        end
      end
      CQR_DETECT: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (detect_ok_i) begin
          s_d.ctrl[CQR_B_RATE_HI:CQR_B_RATE_LO] = detect_rate_i; // RULE_04
          s_d.period = detect_period_i; // RULE_04
          s_d.ctrl[CQR_B_ESTAB] = 1'b0; // RULE_02
          s_d.st = CQR_RX;
          ev[CQR_I_WAKEDONE] = 1'b1; // RULE_02
        end else if (detect_fail_i || s_q.cnt == CQR_CNT_W'(DETECT_CYC - 1)) begin
          s_d.ctrl[CQR_B_RATE_HI:CQR_B_RATE_LO] = CQR_RATE_FAIL; // RULE_05
          s_d.ctrl[CQR_B_ESTAB] = 1'b0; // RULE_05
          s_d.st = CQR_RX;
          ev[CQR_I_WAKEDONE] = 1'b1; // RULE_05
        end
      end
      CQR_TX: begin
        if (tx_queue_empty_i) begin
          s_d.st = CQR_RX; // RULE_15
        end
      end
      default: s_d.st = CQR_IDLE;
    endcase

    // channel a error flags, read clears, new fault wins
    if (rd_now && haddr_i[9:0] == CQR_ADR_ERR_A) begin
      s_d.err = CQR_RST_ERR_A; // RULE_17
    end
    s_d.err[CQR_B_TXFAULT] = s_d.err[CQR_B_TXFAULT] | tx_fault_a_i; // RULE_18
    s_d.err[6:0] = s_d.err[6:0] | other_faults_a_i;
    ev[CQR_I_TXFAULT] = tx_fault_a_i;

    // sticky interrupt status, set wins over clear
    s_d.irq_st = s_d.irq_st | ev;
    s_d.irq    = |(s_d.irq_st & s_d.irq_mk);

    // read data
    if (rd_now) begin
      unique case (haddr_i[9:0])
        CQR_ADR_CTRL_B: s_d.rdata = {24'h000000, s_q.ctrl};
        CQR_ADR_ERR_A:  s_d.rdata = {24'h000000, s_q.err}; // RULE_17
        CQR_ADR_IRQ_ST: s_d.rdata = {30'h00000000, s_q.irq_st};
        CQR_ADR_IRQ_MK: s_d.rdata = {30'h00000000, s_q.irq_mk};
        CQR_ADR_CFG:    s_d.rdata = {31'h00000000, s_q.framer_on_b};
        CQR_ADR_PERIOD: s_d.rdata = {24'h000000, s_q.period}; // RULE_04
        default:        s_d.rdata = 32'h00000000;
      endcase
    end

    // line pin controls, registered from next state
    s_d.drv   = (s_d.st == CQR_WAKE);
    s_d.oe_n  = !(s_d.st == CQR_WAKE || s_d.st == CQR_TX);
    s_d.boost = (s_d.st == CQR_WAKE) && s_d.by_estab; // RULE_03

    // address phase capture
    if (hready_i) begin
      s_d.ap_valid = addr_take;
      s_d.ap_write = hwrite_i;
      s_d.ap_addr  = haddr_i[9:0];
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_q <= '{st: CQR_IDLE, ctrl: CQR_RST_CTRL_B, err: CQR_RST_ERR_A, oe_n: 1'b1,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata_o           = s_q.rdata;
  assign hreadyout_o        = 1'b1;
  assign hresp_o            = 1'b0;
  assign line_pin_b_tx_o    = s_q.drv;
  assign line_pin_b_oe_n_o  = s_q.oe_n;
  assign current_boost_b_o  = s_q.boost; // RULE_03
  assign tx_queue_clear_b_o = s_q.txclr;
  assign rx_queue_clear_b_o = s_q.rxclr;
  assign period_run_b_o     = s_q.run;
  assign rate_sel_b_o       = s_q.ctrl[CQR_B_RATE_HI:CQR_B_RATE_LO];
  assign irq_o              = s_q.irq;
endmodule

// file: bench/cqr_regs_asserts.sv
// Purpose: port checker for cqr_regs
// Assumes: zero-wait ahb-lite, registered line state
// Notes:   bound to every cqr_regs instance
`timescale 1ns/1ps
module cqr_regs_chk
  import cqr_pkg::*;
(
  // clock and bus
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  // line side
  input wire logic        trigger_i,
  input wire logic        tx_queue_empty_i,
  input wire logic        line_pin_b_tx_o,
  input wire logic        line_pin_b_oe_n_o,
  input wire logic        current_boost_b_o,
  input wire logic        tx_queue_clear_b_o,
  input wire logic        rx_queue_clear_b_o,
  input wire logic        period_run_b_o
);
  // ---------------------------------------------------------------
  // control write decode and properties
  // ---------------------------------------------------------------
  logic wr_q;
  always_ff @(posedge ref_clk_i) begin
    wr_q <= reset_n_i && hsel_i && hready_i && htrans_i[1] && hwrite_i
            && haddr_i[9:0] == CQR_ADR_CTRL_B;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_boost; current_boost_b_o |-> line_pin_b_tx_o && !line_pin_b_oe_n_o; endproperty
  property p_wake_rx; $fell(line_pin_b_tx_o) && !$past(current_boost_b_o)
    |-> line_pin_b_oe_n_o; endproperty
  property p_txclr; wr_q && hwdata_i[CQR_B_TXCLR] |-> ##[1:2] tx_queue_clear_b_o; endproperty
  property p_rxclr; wr_q && hwdata_i[CQR_B_RXCLR] |-> ##[1:2] rx_queue_clear_b_o; endproperty
  property p_arm; wr_q && hwdata_i[CQR_B_ARM] && !hwdata_i[CQR_B_SEND] && !period_run_b_o
    && !trigger_i |=> !period_run_b_o; endproperty
  property p_stop; wr_q && !hwdata_i[CQR_B_ARM] |=> !period_run_b_o; endproperty
  property p_send; wr_q && hwdata_i[CQR_B_SEND] && line_pin_b_oe_n_o |=> !line_pin_b_oe_n_o;
  endproperty
  property p_back; !line_pin_b_oe_n_o && !line_pin_b_tx_o && tx_queue_empty_i
    |=> line_pin_b_oe_n_o; endproperty
  a_boost: assert property (p_boost)
    else $error("boost outside wake drive");
  a_wake_rx: assert property (p_wake_rx)
    else $error("no receive after wake");
  a_txclr: assert property (p_txclr)
    else $error("tx clear missing");
  a_rxclr: assert property (p_rxclr)
    else $error("rx clear missing");
  a_arm: assert property (p_arm)
    else $error("arm started timer");
  a_stop: assert property (p_stop)
    else $error("timer not stopped");
  a_send: assert property (p_send)
    else $error("send did not transmit");
  a_back: assert property (p_back)
    else $error("no receive after transmit");
  c_boost: cover property ($rose(current_boost_b_o));
  c_run: cover property ($rose(period_run_b_o));
  c_send: cover property (wr_q && hwdata_i[CQR_B_SEND]);
endmodule

bind cqr_regs cqr_regs_chk i_cqr_regs_chk (.ref_clk_i, .reset_n_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .trigger_i, .tx_queue_empty_i, .line_pin_b_tx_o,
  .line_pin_b_oe_n_o, .current_boost_b_o, .tx_queue_clear_b_o, .rx_queue_clear_b_o,
  .period_run_b_o);

// file: bench/cqr_remote.sv
// Purpose: remote device model on channel b line
// Assumes: answers three cycles after the establish wake pulse
// Notes:   rate and period read inverted outside the answer pulse
`timescale 1ns/1ps
module cqr_remote #(
  parameter logic [1:0] RATE   = 2'h2,
  parameter logic [7:0] PERIOD = 8'h5A
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  // line and bench control
  input  wire logic       boost_i,
  input  wire logic       oe_n_i,
  input  wire logic       drive_i,
  input  wire logic       answer_ok_i,
  input  wire logic       clear_i,
  input  wire logic [3:0] fill_i,
  // detection and queue state
  output logic            ok_o,
  output logic            fail_o,
  output logic      [1:0] rate_o,
  output logic      [7:0] period_o,
  output logic            empty_o
);
  // ---------------------------------------------------------------
  // answer delay and queue count
  // ---------------------------------------------------------------
  logic       boost_q;
  logic [2:0] dly_q;
  logic [4:0] cnt_q;
  wire        ans = dly_q == 3'h1;
  always_ff @(posedge ref_clk_i) begin
    boost_q <= boost_i && reset_n_i;
    if (!reset_n_i) begin
      dly_q <= 3'h0;
    end else if (boost_q && !boost_i) begin
      dly_q <= 3'h3;
    end else if (dly_q != 3'h0) begin
      dly_q <= dly_q - 3'h1;
    end
    if (!reset_n_i || clear_i) begin
      cnt_q <= 5'h0;
    end else if (fill_i != 4'h0) begin
      cnt_q <= cnt_q + {1'b0, fill_i};
    end else if (!oe_n_i && !drive_i && cnt_q != 5'h0) begin
      cnt_q <= cnt_q - 5'h1;
    end
  end
  assign ok_o     = ans && answer_ok_i;
  assign fail_o   = ans && !answer_ok_i;
  assign rate_o   = ans ? RATE : ~RATE;
  assign period_o = ans ? PERIOD : ~PERIOD;
  assign empty_o  = cnt_q == 5'h0;
endmodule

// file: bench/cqr_regs_bench.sv
// Purpose: self-checking bench for cqr_regs
// Assumes: short wake and detect counts
// Notes:   line outputs sampled on the falling edge, read data and hready on the rising edge
`timescale 1ns/1ps
module cqr_regs_bench
  import cqr_pkg::*;
;
  // ---------------------------------------------------------------
  // signals, instances, tasks
  // ---------------------------------------------------------------
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0, trig = 1'b0, fault = 1'b0, ok = 1'b1;
  logic [6:0]  other = 7'h0;
  logic [3:0]  fill = 4'h0;
  logic        hready, hresp, d_ok, d_fail, empty, drv, oe_n, boost, txc, rxc, run, irq, s1, s2;
  logic [1:0]  rate, rsel;
  logic [7:0]  period;
  int          errors = 0, n_checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  cqr_regs #(.WAKE_CYC(4), .DETECT_CYC(8)) i_cqr_regs (.ref_clk_i, .reset_n_i, .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .detect_ok_i(d_ok), .detect_fail_i(d_fail), .detect_rate_i(rate), .detect_period_i(period),
    .trigger_i(trig), .tx_queue_empty_i(empty), .tx_fault_a_i(fault), .other_faults_a_i(other),
    .line_pin_b_tx_o(drv), .line_pin_b_oe_n_o(oe_n), .current_boost_b_o(boost),
    .tx_queue_clear_b_o(txc), .rx_queue_clear_b_o(rxc), .period_run_b_o(run),
    .rate_sel_b_o(rsel), .irq_o(irq));
  cqr_remote i_cqr_remote (.ref_clk_i, .reset_n_i, .boost_i(boost), .oe_n_i(oe_n), .drive_i(drv),
    .answer_ok_i(ok), .clear_i(txc), .fill_i(fill), .ok_o(d_ok), .fail_o(d_fail),
    .rate_o(rate), .period_o(period), .empty_o(empty));
  task automatic finish_test();
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    htrans <= 2'h2;
    haddr  <= {22'h0, a};
    hwrite <= w;
    for (n = 0; n < 2; n++) begin
      @(posedge ref_clk_i);
      if (hready === 1'b1) n = 9;
    end
    htrans <= 2'h0;
    hwdata <= d;
    for (n = 0; n < 2; n++) begin
      @(posedge ref_clk_i);
      if (hready === 1'b1) n = 9;
    end
    if (n < 9) begin
      errors++;
      finish_test();
    end
    rd = hrdata;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_for(input int sel, input logic v);
    int n;
    for (n = 0; n < 300; n++) begin
      @(negedge ref_clk_i);
      if ((sel == 0 ? irq : sel == 1 ? drv : oe_n) === v) return;
    end
    errors++;
    finish_test();
  endtask
  task automatic t_establish(input logic good, input logic [31:0] exp);
    @(posedge ref_clk_i);
    ok <= good;
    wr(CQR_ADR_CFG, 32'h1);
    wr(CQR_ADR_IRQ_MK, 32'h1);
    wr(CQR_ADR_CTRL_B, 32'h20);
    wait_for(0, 1'b1);
    chk(rsel, exp[7:6]);
    rdc(CQR_ADR_CTRL_B, exp);
    if (good) rdc(CQR_ADR_PERIOD, 32'h5A);
    wr(CQR_ADR_IRQ_ST, 32'h1);
    wait_for(0, 1'b0);
  endtask
  task automatic t_wake();
    wr(CQR_ADR_CTRL_B, 32'h10);
    @(negedge ref_clk_i);
    chk(drv, 1);
    wait_for(1, 1'b0);
    chk(oe_n, 1);
    rdc(CQR_ADR_CTRL_B, 32'h0);
  endtask
  task automatic t_send();
    @(posedge ref_clk_i);
    fill <= 4'h3;
    @(posedge ref_clk_i);
    fill <= 4'h0;
    wr(CQR_ADR_CTRL_B, 32'h1);
    @(negedge ref_clk_i);
    chk(oe_n, 0);
    chk(run, 0);
    rdc(CQR_ADR_CTRL_B, 32'h0);
    wait_for(2, 1'b1);
  endtask
  task automatic t_timer();
    wr(CQR_ADR_CTRL_B, 32'h2);
    @(negedge ref_clk_i);
    chk(run, 0);
    wr(CQR_ADR_CTRL_B, 32'h3);
    @(negedge ref_clk_i);
    chk(run, 1);
    wr(CQR_ADR_CTRL_B, 32'h0);
    @(negedge ref_clk_i);
    chk(run, 0);
    wr(CQR_ADR_CTRL_B, 32'h2);
    @(posedge ref_clk_i);
    trig <= 1'b1;
    @(posedge ref_clk_i);
    trig <= 1'b0;
    @(negedge ref_clk_i);
    chk(run, 1);
    wr(CQR_ADR_CTRL_B, 32'h0);
  endtask
  task automatic t_clear();
    s1 = 1'b0;
    s2 = 1'b0;
    wr(CQR_ADR_CTRL_B, 32'h0C);
    repeat (3) begin
      @(negedge ref_clk_i);
      s1 = s1 | txc;
      s2 = s2 | rxc;
    end
    chk(s1, 1);
    chk(s2, 1);
  endtask
  task automatic t_errors();
    @(posedge ref_clk_i);
    fault <= 1'b1;
    other <= 7'h05;
    @(posedge ref_clk_i);
    fault <= 1'b0;
    other <= 7'h00;
    rdc(CQR_ADR_ERR_A, 32'h85);
    rdc(CQR_ADR_ERR_A, 32'h0);
    wr(CQR_ADR_ERR_A, 32'hFF);
    rdc(CQR_ADR_ERR_A, 32'h0);
    rdc(10'h3FC, 32'h0);
    chk(irq, 0);
    wr(CQR_ADR_IRQ_MK, 32'h2);
    wait_for(0, 1'b1);
    wr(CQR_ADR_IRQ_ST, 32'h2);
    wait_for(0, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rdc(CQR_ADR_CTRL_B, 32'h0);
    rdc(CQR_ADR_ERR_A, 32'h0);
    t_establish(1'b1, 32'h80);
    t_establish(1'b0, 32'h0);
    t_wake();
    t_send();
    t_timer();
    t_clear();
    t_errors();
    chk(hresp, 0);
    finish_test();
  end
endmodule
